/* File: pkg/snoop_sync_pkg.sv */
// Purpose: Shared constants for snoop window end and synchronize control
// Assumes: One system clock, 200 MHz
// Notes: Pin signals on the link are active low except the attributes, as on the board
package snoop_sync_pkg;
    localparam int clock_period_ns = 5;
    // Snoop lookup follows the edge that samples window end by this many clocks
    localparam int lookup_delay_clks = 2;
    // Least width of a synchronize request, in clocks
    localparam int sync_min_width_clks = 2;
    localparam int lookup_cnt_w = 2;
    localparam int line_idx_w_default = 4;
    // Line state codes
    localparam logic [1:0] line_invalid = 2'h0;
    localparam logic [1:0] line_shared = 2'h1;
    localparam logic [1:0] line_exclusive = 2'h2;
    localparam logic [1:0] line_modified = 2'h3;
    localparam logic [lookup_cnt_w-1:0] lookup_cnt_load = lookup_cnt_w'(lookup_delay_clks);
    localparam logic [lookup_cnt_w-1:0] lookup_cnt_zero = 2'h0;
endpackage

/* File: pkg/mem_bus_if.sv */
// Purpose: Memory bus link between cache controller and memory bus controller
// Assumes: All signals active low except attributes, single clock
// Notes: Attribute levels are 1 for writeback and 1 for direct-to-modified
`timescale 1ns/1ps
interface mem_bus_if;
    logic bus_guarantee_n;
    logic cacheability_window_end_n;
    logic snoop_window_end_n;
    logic memory_cycle_ready_n;
    logic memory_address_strobe_n;
    logic direct_to_modified_attr;
    logic writeback_or_writethrough_attr;
    logic synchronize_n;
    logic flush_n;
    logic synchronize_active_out_n;
    logic snoop_lookup_cycle_n;

    modport cache_end (
        input bus_guarantee_n, cacheability_window_end_n, snoop_window_end_n,
        input memory_cycle_ready_n, direct_to_modified_attr,
        input writeback_or_writethrough_attr, synchronize_n, flush_n,
        output memory_address_strobe_n, synchronize_active_out_n, snoop_lookup_cycle_n
    );
    modport bus_end (
        output bus_guarantee_n, cacheability_window_end_n, snoop_window_end_n,
        output memory_cycle_ready_n, direct_to_modified_attr,
        output writeback_or_writethrough_attr, synchronize_n, flush_n,
        input memory_address_strobe_n, synchronize_active_out_n, snoop_lookup_cycle_n
    );
endinterface

/* File: rtl/snoop_sync_cache_end.sv */
// Purpose: Snoop window tracking and whole-cache synchronize for the cache side
// Assumes: Bus end keeps its rules; line states kept in a small local array
// Notes: Tag array has no reset; window-end cycles fill it
`timescale 1ns/1ps
module snoop_sync_cache_end #(
    parameter int line_idx_w = snoop_sync_pkg::line_idx_w_default
) (
    input wire logic clock,
    input wire logic reset_n,
    mem_bus_if.cache_end bus,
    input wire logic cycle_pending,
    input wire logic locked_cycle,
    input wire logic snoop_request,
    input wire logic cycle_line_miss,
    input wire logic [line_idx_w-1:0] cycle_line,
    input wire logic inquire_done,
    output logic processor_strobe_block,
    output logic inquire_request,
    output logic [line_idx_w-1:0] inquire_line,
    output logic snoop_writeback_start,
    output logic [1:0] cycle_line_state
);
    localparam int lines = 2 ** line_idx_w;

    typedef enum logic [4:0] {
        sy_idle = 5'h01,
        sy_drain = 5'h02,
        sy_scan = 5'h04,
        sy_inquire = 5'h08,
        sy_write = 5'h10
    } sync_state_t;

    typedef struct packed {
        logic [2:0] sync_pipe;
        logic sync_seen;
        logic window_open;
        logic window_done;
        logic snoop_held;
        logic [snoop_sync_pkg::lookup_cnt_w-1:0] lookup_cnt;
        logic lookup;
        logic wb_pending;
        logic wb_start;
        logic wb_attr;
        logic dm_attr;
        sync_state_t sync_state;
        logic active;
        logic [line_idx_w-1:0] idx;
        logic memory_address_strobe;
        logic [1:0] cur_state;
    } state_t;

    state_t s_q;
    state_t s_d;
    logic [1:0] tags_q [lines];
    logic tag_we;
    logic [1:0] tag_wdata;
    logic [line_idx_w-1:0] tag_waddr;

    logic bgt;
    logic cacheability_window_end_seen;
    logic snoop_window_end;
    logic memory_cycle_ready;
    logic sync_level;

    assign bgt = !bus.bus_guarantee_n;
    assign snoop_window_end = !bus.snoop_window_end_n;
    assign memory_cycle_ready = !bus.memory_cycle_ready_n;
    assign cacheability_window_end_seen = !bus.cacheability_window_end_n;
    assign sync_level = !s_q.sync_pipe[1] && !s_q.sync_pipe[2];

    always_comb begin
        s_d = s_q;
        tag_we = 1'b0;
        tag_wdata = snoop_sync_pkg::line_invalid;
        tag_waddr = cycle_line;
        s_d.sync_pipe = {s_q.sync_pipe[1:0], bus.synchronize_n};
        s_d.lookup = 1'b0;
        s_d.wb_start = 1'b0;
        s_d.memory_address_strobe = 1'b0;
        // ----------------------------------------
        // Snoop window
        // ----------------------------------------
        // Guarantee may share the clock with both window ends; window end wins
        if (bgt && !s_q.window_open && !s_q.window_done) begin
            s_d.window_open = 1'b1;
        end
        // Window end is taken whether or not cacheability window end is seen
        if (snoop_window_end && !s_q.window_done && (s_q.window_open || bgt) &&
                (cacheability_window_end_seen || bus.cacheability_window_end_n)) begin
            s_d.window_open = 1'b0;
            s_d.window_done = 1'b1;
            s_d.wb_attr = bus.writeback_or_writethrough_attr;
            s_d.dm_attr = bus.direct_to_modified_attr;
            if (cycle_line_miss || s_q.active) begin
                tag_we = 1'b1;
                tag_wdata = bus.direct_to_modified_attr ? snoop_sync_pkg::line_modified :
                    (bus.writeback_or_writethrough_attr ? snoop_sync_pkg::line_exclusive :
                    snoop_sync_pkg::line_shared);
            end
            if (s_q.snoop_held || snoop_request) begin
                s_d.lookup_cnt = snoop_sync_pkg::lookup_cnt_load;
                s_d.snoop_held = 1'b0;
            end
        end else if (snoop_request && (s_q.window_open || (bgt && !s_q.window_done))) begin
            // A snoop in the guarantee clock itself must be held, or it is lost
            s_d.snoop_held = 1'b1;
        end else if (snoop_request) begin
            s_d.lookup = 1'b1;
        end
        if (s_q.lookup_cnt != snoop_sync_pkg::lookup_cnt_zero) begin
            s_d.lookup_cnt = s_q.lookup_cnt - 1'b1;
            if (s_q.lookup_cnt == 1) begin
                s_d.lookup = 1'b1;
                s_d.wb_pending = 1'b1;
            end
        end
        // Ready closes the cycle; without window end it also frees held snoops
        if (memory_cycle_ready) begin
            s_d.window_open = 1'b0;
            s_d.window_done = 1'b0;
            if (s_d.snoop_held) begin
                s_d.snoop_held = 1'b0;
                s_d.lookup = 1'b1;
            end
            if (s_q.wb_pending) begin
                s_d.wb_pending = 1'b0;
                s_d.wb_start = 1'b1;
            end
        end
        // ----------------------------------------
        // Synchronize
        // ----------------------------------------
        s_d.sync_seen = s_q.sync_seen || sync_level;
        unique case (s_q.sync_state)
            sy_idle: begin
                if (s_q.sync_seen) begin
                    s_d.sync_state = sy_drain;
                end
            end
            sy_drain: begin
                if (!cycle_pending && !locked_cycle && !s_q.window_open) begin
                    s_d.sync_state = sy_scan;
                    s_d.active = 1'b1;
                    s_d.idx = '0;
                end
            end
            sy_scan: begin
                s_d.sync_seen = 1'b0;
                if (tags_q[s_q.idx] == snoop_sync_pkg::line_modified) begin
                    s_d.sync_state = sy_inquire;
                end else if (s_q.idx == line_idx_w'(lines - 1)) begin
                    s_d.sync_state = sy_idle;
                    s_d.active = 1'b0;
                end else begin
                    s_d.idx = s_q.idx + 1'b1;
                end
            end
            sy_inquire: begin
                s_d.sync_seen = 1'b0;
                if (inquire_done) begin
                    s_d.sync_state = sy_write;
                    s_d.memory_address_strobe = 1'b1;
                end
            end
            sy_write: begin
                s_d.sync_seen = 1'b0;
                if (memory_cycle_ready) begin
                    tag_we = 1'b1;
                    tag_waddr = s_q.idx;
                    tag_wdata = snoop_sync_pkg::line_exclusive;
                    s_d.sync_state = sy_scan;
                end
            end
            default: begin
                s_d.sync_state = sy_idle;
            end
        endcase
        if (!bus.flush_n) begin
            s_d.sync_state = sy_idle;
            s_d.active = 1'b0;
            s_d.sync_seen = 1'b0;
        end
        s_d.cur_state = tag_we ? tag_wdata : tags_q[cycle_line];
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            s_q <= '{sync_pipe: 3'h7, sync_state: sy_idle, lookup_cnt: '0, idx: '0,
                cur_state: 2'h0, default: 1'b0};
        end else begin
            s_q <= s_d;
        end
    end

    // Tag array is not reset; window-end cycles and synchronize writebacks write it, flush leaves it
    always_ff @(posedge clock) begin
        if (tag_we) begin
            tags_q[tag_waddr] <= tag_wdata;
        end
    end

    assign bus.memory_address_strobe_n = !s_q.memory_address_strobe;
    assign bus.synchronize_active_out_n = !s_q.active;
    assign bus.snoop_lookup_cycle_n = !s_q.lookup;
    assign processor_strobe_block = s_q.sync_state != sy_idle;
    assign inquire_request = s_q.sync_state == sy_inquire;
    assign inquire_line = s_q.idx;
    assign snoop_writeback_start = s_q.wb_start;
    assign cycle_line_state = s_q.cur_state;
endmodule

/* File: rtl/snoop_sync_bus_end.sv */
// Purpose: Memory bus controller end driving window ends and synchronize
// Assumes: Simple command inputs from user logic, one cycle at a time
// Notes: Holds a synchronize request for the least width before release
`timescale 1ns/1ps
module snoop_sync_bus_end (
    input wire logic clock,
    input wire logic reset_n,
    mem_bus_if.bus_end bus,
    input wire logic start_cycle,
    input wire logic needs_window,
    input wire logic wb_attr,
    input wire logic dm_attr,
    input wire logic ready_now,
    input wire logic sync_request,
    input wire logic flush_request,
    output logic sync_active,
    output logic lookup_seen,
    output logic cache_strobe_seen
);
    typedef struct packed {
        logic bgt;
        logic cacheability_window_end;
        logic snoop_window_end;
        logic memory_cycle_ready;
        logic wb;
        logic dm;
        logic [1:0] sync_cnt;
        logic flush;
    } state_t;

    state_t s_q;
    state_t s_d;

    always_comb begin
        s_d = s_q;
        s_d.bgt = start_cycle;
        // Window ends given together with guarantee; legal and fastest
        s_d.cacheability_window_end = start_cycle;
        s_d.snoop_window_end = start_cycle && needs_window;
        s_d.wb = wb_attr;
        s_d.dm = dm_attr;
        s_d.memory_cycle_ready = ready_now;
        s_d.flush = flush_request;
        if (sync_request && s_q.sync_cnt == 2'h0) begin
            s_d.sync_cnt = 2'(snoop_sync_pkg::sync_min_width_clks);
        end else if (s_q.sync_cnt != 2'h0) begin
            s_d.sync_cnt = s_q.sync_cnt - 1'b1;
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign bus.bus_guarantee_n = !s_q.bgt;
    assign bus.cacheability_window_end_n = !s_q.cacheability_window_end;
    assign bus.snoop_window_end_n = !s_q.snoop_window_end;
    assign bus.memory_cycle_ready_n = !s_q.memory_cycle_ready;
    assign bus.writeback_or_writethrough_attr = s_q.wb;
    assign bus.direct_to_modified_attr = s_q.dm;
    assign bus.synchronize_n = !(s_q.sync_cnt != 2'h0);
    assign bus.flush_n = !s_q.flush;
    assign sync_active = !bus.synchronize_active_out_n;
    assign lookup_seen = !bus.snoop_lookup_cycle_n;
    assign cache_strobe_seen = !bus.memory_address_strobe_n;
endmodule

/* File: verif/snoop_sync_sva.sv */
// Purpose: Link checks between cache end and bus end
// Assumes: One clock, reset_n active low
// Notes: Sees only the link signals
`timescale 1ns/1ps
module snoop_sync_sva (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic bus_guarantee_n,
    input wire logic cacheability_window_end_n,
    input wire logic snoop_window_end_n,
    input wire logic memory_cycle_ready_n,
    input wire logic memory_address_strobe_n,
    input wire logic synchronize_n,
    input wire logic flush_n,
    input wire logic synchronize_active_out_n,
    input wire logic snoop_lookup_cycle_n
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!reset_n);
    strobe_in_sync_a: assert property (!memory_address_strobe_n |-> !synchronize_active_out_n)
        else $error("strobe outside synchronize");
    strobe_pulse_a: assert property (!memory_address_strobe_n |=> memory_address_strobe_n)
        else $error("strobe longer than one cycle");
    // A second strobe before ready would stack writebacks with no buffer
    ready_gap_a: assert property ($fell(memory_address_strobe_n) |=>
        memory_address_strobe_n until !memory_cycle_ready_n) else $error("strobe before ready");
    flush_abort_a: assert property (!flush_n && !synchronize_active_out_n |->
        ##[1:2] synchronize_active_out_n) else $error("flush did not abort");
    sync_width_a: assert property ($fell(synchronize_n) |=> !synchronize_n)
        else $error("synchronize pulse too short");
    window_order_a: assert property (!snoop_window_end_n |-> !cacheability_window_end_n)
        else $error("window end before cacheability end");
    window_grant_a: assert property (!snoop_window_end_n |-> !bus_guarantee_n)
        else $error("window end without guarantee");
    active_hold_a: assert property ($fell(synchronize_active_out_n) && flush_n |=>
        !synchronize_active_out_n) else $error("active dropped at once");
    sync_run_c: cover property ($fell(synchronize_active_out_n));
    lookup_c: cover property (!snoop_lookup_cycle_n);
    abort_c: cover property (!flush_n && !synchronize_active_out_n);
endmodule

/* File: verif/tb_top.sv */
// Purpose: Both ends joined, driven from their user sides
// Assumes: 200 MHz clock, inputs driven at falling edge
// Notes: Line states written by window-end cycles before synchronize
`timescale 1ns/1ps
module tb_top;
    logic clock = 1'b0;
    logic reset_n = 1'b0;
    logic start_cycle, needs_window, wb_attr, dm_attr, ready_now, sync_request, flush_request;
    logic cycle_pending, locked_cycle, snoop_request, cycle_line_miss, inquire_done;
    logic [3:0] cycle_line;
    logic sync_active, lookup_seen, cache_strobe_seen, processor_strobe_block;
    logic inquire_request, snoop_writeback_start;
    logic [3:0] inquire_line;
    logic [1:0] cycle_line_state;
    int fail_count = 0;
    int n_checks = 0;
    always #2.5 clock = ~clock;
    mem_bus_if mem_bus_if_inst ();
    snoop_sync_cache_end #(.line_idx_w(4)) snoop_sync_cache_end_inst (.clock(clock),
        .reset_n(reset_n), .bus(mem_bus_if_inst), .cycle_pending(cycle_pending),
        .locked_cycle(locked_cycle), .snoop_request(snoop_request),
        .cycle_line_miss(cycle_line_miss), .cycle_line(cycle_line), .inquire_done(inquire_done),
        .processor_strobe_block(processor_strobe_block), .inquire_request(inquire_request),
        .inquire_line(inquire_line), .snoop_writeback_start(snoop_writeback_start),
        .cycle_line_state(cycle_line_state));
    snoop_sync_bus_end snoop_sync_bus_end_inst (.clock(clock), .reset_n(reset_n),
        .bus(mem_bus_if_inst), .start_cycle(start_cycle), .needs_window(needs_window),
        .wb_attr(wb_attr), .dm_attr(dm_attr), .ready_now(ready_now),
        .sync_request(sync_request), .flush_request(flush_request), .sync_active(sync_active),
        .lookup_seen(lookup_seen), .cache_strobe_seen(cache_strobe_seen));
    snoop_sync_sva snoop_sync_sva_inst (.clock(clock), .reset_n(reset_n),
        .bus_guarantee_n(mem_bus_if_inst.bus_guarantee_n),
        .cacheability_window_end_n(mem_bus_if_inst.cacheability_window_end_n),
        .snoop_window_end_n(mem_bus_if_inst.snoop_window_end_n),
        .memory_cycle_ready_n(mem_bus_if_inst.memory_cycle_ready_n),
        .memory_address_strobe_n(mem_bus_if_inst.memory_address_strobe_n),
        .synchronize_n(mem_bus_if_inst.synchronize_n), .flush_n(mem_bus_if_inst.flush_n),
        .synchronize_active_out_n(mem_bus_if_inst.synchronize_active_out_n),
        .snoop_lookup_cycle_n(mem_bus_if_inst.snoop_lookup_cycle_n));
    // ----------------------------------------
    // Compare and closing tasks
    // ----------------------------------------
    task automatic check_bit(input string what, input logic exp, input logic got);
        n_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch %s expected %b seen %b", what, exp, got);
        end
    endtask
    task automatic check_state(input string what, input logic [1:0] exp, input logic [1:0] got);
        n_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic check_count(input string what, input int exp, input int got);
        n_checks++;
        if (got != exp) begin
            fail_count++;
            $display("mismatch %s expected %0d seen %0d", what, exp, got);
        end
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic timed_out(input string what);
        fail_count++;
        $display("mismatch %s expected done seen timeout", what);
        conclude();
    endtask
    task automatic tick();
        @(negedge clock);
    endtask
    // ----------------------------------------
    // Access tasks
    // ----------------------------------------
    task automatic write_line(input int idx, input logic wb, input logic dm, input logic [1:0] exp);
        start_cycle = 1'b1;
        wb_attr = wb;
        dm_attr = dm;
        cycle_line = 4'(idx);
        tick();
        start_cycle = 1'b0;
        repeat (3) tick();
        check_state("line state", exp, cycle_line_state);
        ready_now = 1'b1;
        tick();
        ready_now = 1'b0;
        repeat (2) tick();
    endtask
    // Snoop raised in the window-end clock: lookup three clocks later, writeback after ready
    task automatic delayed_snoop();
        start_cycle = 1'b1;
        tick();
        start_cycle = 1'b0;
        check_bit("guarantee", 1'b0, mem_bus_if_inst.bus_guarantee_n);
        check_bit("window end", 1'b0, mem_bus_if_inst.snoop_window_end_n);
        snoop_request = 1'b1;
        tick();
        snoop_request = 1'b0;
        tick();
        check_bit("early lookup", 1'b0, lookup_seen);
        tick();
        check_bit("lookup", 1'b1, lookup_seen);
        check_bit("early writeback", 1'b0, snoop_writeback_start);
        ready_now = 1'b1;
        tick();
        ready_now = 1'b0;
        check_bit("writeback before ready", 1'b0, snoop_writeback_start);
        tick();
        check_bit("writeback", 1'b1, snoop_writeback_start);
        repeat (2) tick();
    endtask
    // No window end: a snoop taken in the guarantee clock waits for ready
    task automatic blocked_snoop();
        needs_window = 1'b0;
        start_cycle = 1'b1;
        tick();
        start_cycle = 1'b0;
        snoop_request = 1'b1;
        tick();
        snoop_request = 1'b0;
        repeat (3) tick();
        check_bit("blocked lookup", 1'b0, lookup_seen);
        ready_now = 1'b1;
        tick();
        ready_now = 1'b0;
        check_bit("lookup before ready", 1'b0, lookup_seen);
        tick();
        check_bit("lookup after ready", 1'b1, lookup_seen);
        needs_window = 1'b1;
        repeat (2) tick();
    endtask
    task automatic run_sync(input int exp_wb, input bit abort);
        int k, kf, wbs, inq, looks;
        wbs = 0;
        inq = 0;
        looks = 0;
        kf = 0;
        cycle_pending = 1'b1;
        locked_cycle = 1'b1;
        sync_request = 1'b1;
        tick();
        sync_request = 1'b0;
        repeat (8) tick();
        check_bit("active while busy", 1'b0, sync_active);
        cycle_pending = 1'b0;
        locked_cycle = 1'b0;
        k = 0;
        while (sync_active !== 1'b1) begin
            k++;
            if (k > 20) timed_out("sync start");
            tick();
        end
        check_bit("processor strobe held", 1'b1, processor_strobe_block);
        k = 0;
        while (sync_active === 1'b1) begin
            k++;
            if (k > 2000) timed_out("sync end");
            snoop_request = (k == 1);
            sync_request = (k == 4);
            if (lookup_seen === 1'b1) looks++;
            inquire_done = (inquire_request === 1'b1) && !inquire_done;
            if (inquire_done) begin
                inq++;
                check_bit("inquire line", 1'b1, inquire_line % 3 == 0);
            end
            ready_now = (cache_strobe_seen === 1'b1);
            if (ready_now) wbs++;
            if (abort && wbs == 1 && kf == 0) kf = k;
            flush_request = (kf != 0);
            tick();
        end
        {snoop_request, sync_request, inquire_done, ready_now, flush_request} = 5'h00;
        check_bit("processor strobe freed", 1'b0, processor_strobe_block);
        if (abort) check_bit("quick abort", 1'b1, (k - kf) <= 4);
        else begin
            check_count("writebacks", exp_wb, wbs);
            check_count("inquires", exp_wb, inq);
            check_count("snoop lookups", 1, looks);
        end
        repeat (4) tick();
    endtask
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        {start_cycle, wb_attr, dm_attr, ready_now, sync_request, flush_request} = 6'h00;
        {cycle_pending, locked_cycle, snoop_request, inquire_done} = 4'h0;
        needs_window = 1'b1;
        cycle_line_miss = 1'b1;
        cycle_line = 4'h0;
        repeat (3) @(posedge clock);
        @(negedge clock) reset_n = 1'b1;
        tick();
        check_bit("idle active", 1'b0, sync_active);
        for (int i = 0; i < 16; i++) begin
            write_line(i, i % 3 == 1, i % 3 == 0,
                (i % 3 == 0) ? snoop_sync_pkg::line_modified :
                (i % 3 == 1) ? snoop_sync_pkg::line_exclusive : snoop_sync_pkg::line_shared);
        end
        delayed_snoop();
        blocked_snoop();
        run_sync(6, 1'b0);
        run_sync(0, 1'b0);
        write_line(0, 1'b0, 1'b1, snoop_sync_pkg::line_modified);
        write_line(1, 1'b0, 1'b1, snoop_sync_pkg::line_modified);
        run_sync(0, 1'b1);
        conclude();
    end
endmodule
